// File: core/cgc_pkg.sv
// Package for the clock generation control block.
// Assumes a single 100 MHz control clock; all settings arrive as plain ports.
package cgc_pkg;
  // System clock source codes
  typedef enum logic [1:0] {
    CGC_SRC_LOW_OSC = 2'b00,
    CGC_SRC_MAIN = 2'b01,
    CGC_SRC_PLL = 2'b10
  } cgc_src_type;
  // PLL source codes
  localparam logic CGC_PLLSRC_MAIN = 1'b0;
  localparam logic CGC_PLLSRC_HSOSC = 1'b1;
  // PLL factor in half steps: 10x -> 20, 30x -> 60
  localparam int CGC_MUL_W = 6;
  localparam logic [5:0] CGC_MUL_MIN = 6'h14;
  localparam logic [5:0] CGC_MUL_MAX = 6'h3C;
  localparam logic [5:0] CGC_MUL_RST = 6'h14;
  // Oscillation stop timeout
  localparam int CGC_OSC_STOP_NS = 1000;
  localparam int CGC_CLK_NS = 10;
  localparam int CGC_STOP_CYC = CGC_OSC_STOP_NS / CGC_CLK_NS;
  localparam int CGC_CNT_W = 8;
  // Reset values
  localparam logic CGC_MAIN_EN_RST = 1'b0;
  localparam logic CGC_STOP_DET_RST = 1'b0;
endpackage

// File: core/cgc_osc_mon.sv
// Main oscillator stop monitor.
// Assumes osc_tick_i is a level from the oscillator domain, toggling while alive.
`timescale 1ns/1ps
`default_nettype none
module cgc_osc_mon #(
  parameter int STOP_CYC = cgc_pkg::CGC_STOP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic osc_tick_i,
  output logic stopped_o
);
  import cgc_pkg::*;
  logic sync1_q, sync2_q, prev_q;
  logic [CGC_CNT_W-1:0] cnt_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= osc_tick_i;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Counts cycles since last oscillator edge
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      stopped_o <= 1'b0;
    end else if (!enable_i || (sync2_q != prev_q)) begin
      cnt_q <= '0;
      stopped_o <= 1'b0;
    end else if (cnt_q == CGC_CNT_W'(STOP_CYC)) begin
      stopped_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: core/cgc_top.sv
// Clock generation control: source select, PLL factor, stop fallback.
// Assumes software drives the plain setting ports synchronous to ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module cgc_top #(
  parameter int STOP_CYC = cgc_pkg::CGC_STOP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic main_osc_en_i,
  input wire logic main_osc_tick_i,
  input wire cgc_pkg::cgc_src_type src_req_i,
  input wire logic src_req_we_i,
  input wire logic pll_src_i,
  input wire logic [cgc_pkg::CGC_MUL_W-1:0] pll_mul_i,
  input wire logic pll_mul_we_i,
  input wire logic stop_flag_clr_i,
  output cgc_pkg::cgc_src_type sys_src_o,
  output logic main_osc_run_o,
  output logic [cgc_pkg::CGC_MUL_W-1:0] pll_mul_o,
  output logic pll_mul_err_o,
  output logic osc_stop_flag_o
);
  import cgc_pkg::*;
  logic stopped;
  logic stop_q;
  logic pll_src_q;
  logic fallback;

  cgc_osc_mon #(.STOP_CYC(STOP_CYC)) u_mon (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .enable_i(main_osc_run_o),
    .osc_tick_i(main_osc_tick_i),
    .stopped_o(stopped)
  );

  // Oscillator stays off until software enables it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      main_osc_run_o <= CGC_MAIN_EN_RST;
    end else begin
      main_osc_run_o <= main_osc_en_i;
    end
  end

  // Out of range factors are refused and flagged
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_mul_o <= CGC_MUL_RST;
      pll_mul_err_o <= 1'b0;
    end else if (pll_mul_we_i) begin
      if (pll_mul_i >= CGC_MUL_MIN && pll_mul_i <= CGC_MUL_MAX) begin
        pll_mul_o <= pll_mul_i;
        pll_mul_err_o <= 1'b0;
      end else begin
        pll_mul_err_o <= 1'b1;
      end
    end
  end

  // PLL source is a plain setting from the same clock domain
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_src_q <= CGC_PLLSRC_MAIN;
    end else begin
      pll_src_q <= pll_src_i;
    end
  end

  // HSOSC-fed PLL as system clock is immune to main stop
  assign fallback = stopped &&
    !(sys_src_o == CGC_SRC_PLL && pll_src_q == CGC_PLLSRC_HSOSC);

  // Sticky stop flag; a new detection wins over the clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stop_q <= CGC_STOP_DET_RST;
    end else if (fallback) begin
      stop_q <= 1'b1;
    end else if (stop_flag_clr_i) begin
      stop_q <= 1'b0;
    end
  end

  // Output copy of the flag, raised together with stop_q on the edge after detection
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osc_stop_flag_o <= 1'b0;
    end else begin
      osc_stop_flag_o <= stop_q || fallback;
    end
  end

  // Source selection: reset to low-speed, switch on software write, or back to low-speed on fallback
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_src_o <= CGC_SRC_LOW_OSC;
    end else if (fallback && sys_src_o != CGC_SRC_LOW_OSC) begin
      sys_src_o <= CGC_SRC_LOW_OSC;
    end else if (src_req_we_i && !fallback) begin
      sys_src_o <= src_req_i;
    end
  end

  a_reset_src: assert property (@(posedge ref_clk_i)
    $rose(rstn_i) |-> sys_src_o == CGC_SRC_LOW_OSC)
    else $error("source not low-speed after reset");
  a_osc_off: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !$past(main_osc_en_i) |-> !main_osc_run_o)
    else $error("oscillator runs without enable");
  a_mul_range: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pll_mul_o >= CGC_MUL_MIN && pll_mul_o <= CGC_MUL_MAX)
    else $error("pll factor out of range");
  a_mul_err: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pll_mul_we_i && pll_mul_i > CGC_MUL_MAX |=> pll_mul_err_o
      && $stable(pll_mul_o))
    else $error("bad factor accepted");
  a_pll_sw: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sys_src_o == CGC_SRC_PLL && $past(sys_src_o) != CGC_SRC_PLL
      |-> $past(src_req_we_i))
    else $error("pll selected without software");
  a_fallback: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    fallback |=> sys_src_o == CGC_SRC_LOW_OSC ##1 osc_stop_flag_o)
    else $error("no fallback on stop");
  a_high_speed_onchip_osc_keep: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    stopped && sys_src_o == CGC_SRC_PLL && pll_src_q == CGC_PLLSRC_HSOSC
      && !src_req_we_i |=> sys_src_o == CGC_SRC_PLL)
    else $error("hsosc pll dropped on stop");
  a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    stop_q && !stop_flag_clr_i |=> stop_q)
    else $error("stop flag lost");

  // Stop flag behaviour
  a_flag_set: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    fallback |=> stop_q)
    else $error("stop flag not set");
  a_flag_out: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    stop_q |=> osc_stop_flag_o)
    else $error("stop flag output low");
  a_flag_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !stop_q && !fallback |=> !osc_stop_flag_o)
    else $error("stop flag output without stop");
  a_flag_clear: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !fallback && stop_flag_clr_i |=> !stop_q)
    else $error("stop flag not cleared");

  // Source selection behaviour
  a_src_take: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    src_req_we_i && !fallback |=> sys_src_o == $past(src_req_i))
    else $error("source write not taken");
  a_src_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !src_req_we_i && !fallback |=> $stable(sys_src_o))
    else $error("source changed without write");
  a_fall_block: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    fallback && src_req_we_i |=> sys_src_o == CGC_SRC_LOW_OSC)
    else $error("source write during fallback");
  a_low_stays: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    sys_src_o == CGC_SRC_LOW_OSC && !src_req_we_i
      |=> sys_src_o == CGC_SRC_LOW_OSC)
    else $error("low-speed source left without write");
  a_main_fall: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    stopped && sys_src_o == CGC_SRC_MAIN |-> fallback)
    else $error("main source kept after stop");
  a_high_speed_onchip_osc_nofall: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    sys_src_o == CGC_SRC_PLL && pll_src_q == CGC_PLLSRC_HSOSC |-> !fallback)
    else $error("fallback with high-speed fed pll");

  // Factor and oscillator enable behaviour
  a_mul_low: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pll_mul_we_i && pll_mul_i < CGC_MUL_MIN
      |=> pll_mul_err_o && $stable(pll_mul_o))
    else $error("low factor accepted");
  a_mul_take: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    pll_mul_we_i && pll_mul_i >= CGC_MUL_MIN && pll_mul_i <= CGC_MUL_MAX
      |=> pll_mul_o == $past(pll_mul_i) && !pll_mul_err_o)
    else $error("legal factor refused");
  a_mul_hold: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !pll_mul_we_i |=> $stable(pll_mul_o) && $stable(pll_mul_err_o))
    else $error("factor changed without write");
  a_run_on: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    main_osc_en_i |=> main_osc_run_o)
    else $error("oscillator not started");
  a_mon_off: assert property (
    @(posedge ref_clk_i) disable iff (!rstn_i)
    !main_osc_run_o |=> !stopped)
    else $error("stop seen while oscillator off");

  c_pll: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    sys_src_o == CGC_SRC_PLL);
  c_fall: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    fallback && sys_src_o == CGC_SRC_PLL);
  c_high_speed_onchip_osc: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    stopped && !fallback);
  c_mul_err: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    pll_mul_err_o);
  c_flag_clr: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
    stop_q && stop_flag_clr_i && !fallback);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Testbench for the clock generation control block.
// Assumes cgc_top alone, with a shortened stop timeout; drives all ports.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cgc_pkg::*;
  logic ref_clk_i, rstn_i, osc_en, tick, tick_on, src_we, pll_src;
  logic mul_we, clr, run, err, flag;
  cgc_src_type src_req, sys_src;
  logic [5:0] mul_in, mul_out, prev;
  int failures = 0;
  int samples_checked = 0;

  cgc_top #(.STOP_CYC(10)) cgc_top_i (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .main_osc_en_i(osc_en), .main_osc_tick_i(tick),
    .src_req_i(src_req), .src_req_we_i(src_we), .pll_src_i(pll_src),
    .pll_mul_i(mul_in), .pll_mul_we_i(mul_we), .stop_flag_clr_i(clr),
    .sys_src_o(sys_src), .main_osc_run_o(run), .pll_mul_o(mul_out),
    .pll_mul_err_o(err), .osc_stop_flag_o(flag));

  initial begin
    ref_clk_i = 0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Live oscillator stand-in
  always @(negedge ref_clk_i) if (tick_on) tick <= ~tick;

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_src(input cgc_src_type s);
    @(negedge ref_clk_i) src_req = s;
    src_we = 1;
    @(negedge ref_clk_i) src_we = 0;
  endtask
  task automatic wr_mul(input logic [5:0] v);
    @(negedge ref_clk_i) mul_in = v;
    mul_we = 1;
    @(negedge ref_clk_i) mul_we = 0;
  endtask

  task automatic t_reset;
    chk("source", sys_src, CGC_SRC_LOW_OSC);
    chk("run", run, 0);
    chk("factor", mul_out, CGC_MUL_RST);
  endtask
  task automatic t_mul;
    logic [5:0] tbl[5] = '{6'h13, 6'h14, 6'h3C, 6'h3D, 6'h27};
    prev = CGC_MUL_RST;
    foreach (tbl[i]) begin
      wr_mul(tbl[i]);
      if (tbl[i] >= 6'h14 && tbl[i] <= 6'h3C) prev = tbl[i];
      chk("factor", mul_out, prev);
      chk("range err", err, tbl[i] < 6'h14 || tbl[i] > 6'h3C);
    end
  endtask
  task automatic t_fallback;
    osc_en = 1;
    tick_on = 1;
    repeat (12) @(negedge ref_clk_i);
    chk("run", run, 1);
    wr_src(CGC_SRC_MAIN);
    repeat (30) @(negedge ref_clk_i);
    chk("source live", sys_src, CGC_SRC_MAIN);
    tick_on = 0;
    for (int i = 0; i < 40 && sys_src !== CGC_SRC_LOW_OSC; i++)
      @(negedge ref_clk_i);
    chk("fallback", sys_src, CGC_SRC_LOW_OSC);
    @(negedge ref_clk_i);
    chk("flag", flag, 1);
  endtask
  task automatic t_hsosc;
    tick_on = 1;
    clr = 1;
    pll_src = CGC_PLLSRC_HSOSC;
    repeat (12) @(negedge ref_clk_i);
    clr = 0;
    chk("flag clear", flag, 0);
    wr_src(CGC_SRC_PLL);
    chk("pll select", sys_src, CGC_SRC_PLL);
    tick_on = 0;
    repeat (40) @(negedge ref_clk_i);
    chk("no fallback", sys_src, CGC_SRC_PLL);
  endtask

  initial begin
    {rstn_i, osc_en, tick, tick_on, src_we, mul_we, clr} = '0;
    pll_src = CGC_PLLSRC_MAIN;
    src_req = CGC_SRC_LOW_OSC;
    // Nothing here raises the core clock or stops modules
    mul_in = CGC_MUL_RST;
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1;
    @(negedge ref_clk_i);
    t_reset();
    t_mul();
    t_fallback();
    t_hsosc();
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
